// >>> rtl/ccp_capture_events.sv
/*
  Capture event source: synchronises pin and received-message pulse,
  detects edges and applies the capture prescaler.
  Assumes pin inputs are asynchronous to i_clk.
*/
`include "ccp_regs.svh"

module ccp_capture_events (
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic       i_ce,
  input  wire logic       i_pin,
  input  wire logic       i_can_rx,
  input  wire logic       i_can_sel,
  input  wire logic [3:0] i_mode,
  input  wire logic       i_clear,
  output logic            o_event
);
  logic [2:0] pin_s;       // Two sync stages plus history
  logic [2:0] can_s;       // Two sync stages plus history
  logic [3:0] pre_cnt;     // Prescaler counter
  logic [3:0] next_pre_cnt;
  logic       src_rise;
  logic       src_fall;
  logic [3:0] limit;

  // Edge detection on stages two and three only
  always_comb begin
    src_rise = 1'b0;
    src_fall = 1'b0;
    if (i_can_sel) begin
      src_rise = can_s[1] & ~can_s[2];
    end else begin
      src_rise = pin_s[1] & ~pin_s[2];
      src_fall = ~pin_s[1] & pin_s[2];
    end
  end

  always_comb begin
    limit        = 4'h0;
    o_event      = 1'b0;
    next_pre_cnt = pre_cnt;
    case (i_mode)
      `CCP_MODE_CAP_FALL:   o_event = src_fall;
      `CCP_MODE_CAP_RISE:   o_event = src_rise;
      `CCP_MODE_CAP_CAN:    o_event = src_rise;
      `CCP_MODE_CAP_RISE4:  limit = `CCP_PRESCALE_4;
      `CCP_MODE_CAP_RISE16: limit = `CCP_PRESCALE_16;
      default:              limit = 4'h0;
    endcase
    if (limit != 4'h0 && src_rise) begin
      o_event      = (pre_cnt >= limit);
      next_pre_cnt = (pre_cnt >= limit) ? 4'h0 : pre_cnt + 4'h1;
    end
    // clear when off or not capturing
    if (i_clear) begin
      next_pre_cnt = 4'h0;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pin_s   <= 3'h0;
      can_s   <= 3'h0;
      pre_cnt <= 4'h0;
    end else if (i_ce) begin
      pin_s   <= {pin_s[1:0], i_pin};
      can_s   <= {can_s[1:0], i_can_rx};
      pre_cnt <= next_pre_cnt;
    end
  end
endmodule : ccp_capture_events

// >>> rtl/ccp_pkg.sv
/*
  Types shared by the capture/compare/PWM unit.
  Assumes ccp_regs.svh supplies the numeric codes.
*/
package ccp_pkg;

  // Operating class decoded from the mode field
  typedef enum logic [2:0] {
    KIND_OFF,
    KIND_RESERVED,
    KIND_CAPTURE,
    KIND_COMPARE,
    KIND_PWM
  } mode_kind_t;

endpackage : ccp_pkg

// >>> rtl/ccp_pwm_gen.sv
/*
  PWM output latch: set at period end if the new duty is non-zero, cleared when the buffered duty
  matches the extended time base. Assumes time-base inputs are on i_clk.
*/
module ccp_pwm_gen #(
  parameter int DUTY_W = 10
) (
  input  wire logic              i_clk,
  input  wire logic              i_rst,
  input  wire logic              i_ce,
  input  wire logic              i_active,
  input  wire logic              i_period_end,
  input  wire logic [DUTY_W-1:0] i_tb_count,
  input  wire logic [DUTY_W-1:0] i_duty_new,
  input  wire logic [7:0]        i_duty_high,
  output logic                   o_level
);
  logic [1:0] low_latch;      // Buffered duty low bits
  logic [1:0] next_low_latch;
  logic       next_level;
  logic [DUTY_W-1:0] tb_next; // Time base one step ahead

  // Clear one step early: high time equals duty
  assign tb_next = i_tb_count + {{(DUTY_W-1){1'b0}}, 1'b1};

  always_comb begin
    next_low_latch = low_latch;
    next_level     = o_level;
    if (!i_active) begin
      // latch low when not in PWM
      next_level = 1'b0;
    end else if (i_period_end) begin
      next_low_latch = i_duty_new[1:0];
      next_level     = (i_duty_new != '0);
    end else if ({i_duty_high, low_latch} == tb_next) begin
      next_level = 1'b0;
    end
  end

  // State registers
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      low_latch <= 2'h0;
      o_level   <= 1'b0;
    end else if (i_ce) begin
      low_latch <= next_low_latch;
      o_level   <= next_level;
    end
  end
endmodule : ccp_pwm_gen

// >>> rtl/ccp_regs.svh
/*
  Register offsets, field positions, mode codes and counts of the
  capture/compare/PWM unit. Assumes a byte-wide register port with a
  two-bit address; holds definitions only.
*/
`ifndef CCP_REGS_SVH
`define CCP_REGS_SVH

// Register offsets on the byte port
`define CCP_OFS_VALUE_LOW   2'h0
`define CCP_OFS_VALUE_HIGH  2'h1
`define CCP_OFS_CONTROL     2'h2
`define CCP_OFS_STATUS      2'h3

// Control register fields and reset value
`define CCP_CTRL_RESET      8'h00
`define CCP_CTRL_MODE_MSB   3
`define CCP_CTRL_DUTY_MSB   5
`define CCP_CTRL_DUTY_LSB   4

// Status register fields
`define CCP_STAT_FLAG       0
`define CCP_STAT_ENABLE     1

// Mode select codes
`define CCP_MODE_OFF        4'h0
`define CCP_MODE_RESERVED   4'h1
`define CCP_MODE_CMP_TOGGLE 4'h2
`define CCP_MODE_CAP_CAN    4'h3
`define CCP_MODE_CAP_FALL   4'h4
`define CCP_MODE_CAP_RISE   4'h5
`define CCP_MODE_CAP_RISE4  4'h6
`define CCP_MODE_CAP_RISE16 4'h7
`define CCP_MODE_CMP_HIGH   4'h8
`define CCP_MODE_CMP_LOW    4'h9
`define CCP_MODE_CMP_SOFT   4'hA
`define CCP_MODE_CMP_TRIG   4'hB

// Capture prescale counts
`define CCP_PRESCALE_4      4'h3
`define CCP_PRESCALE_16     4'hF

`endif

// >>> rtl/ccp_unit.sv
/*
  Capture/compare/PWM unit: 16-bit value register, control register,
  capture from pin or received-message pulse, compare against timer one
  or three, special event trigger and a 10-bit PWM output latch.
  Assumes a byte register port on I_CLK, timer counts and PWM time base
  on I_CLK, and an external port direction bit for the shared pin.
  Timer counts are compared unsynchronised: the source must share
  I_CLK. A capture-to-capture mode change keeps the prescaler count
  and raises a false flag; software writes zero first. The high
  value byte is read-only in PWM mode.
*/
// The register offsets and the plain strobed port were left to the implementer.
// Notes on behaviour
// - Prescaler counter cleared when off or not capturing
// - Direct prescaler switch may flag, keeps count
// - Message received edge causes timestamp capture
// - Timestamp select swaps pin for message signal
// - Compare value continuously against selected timer
// - Match drives pin high, low, toggles, holds
// - Match sets flag with pin action
// - Control zero forces compare latch low
// - Software mode only sets flag, pin untouched
// - Special trigger resets selected timer pair
// - Special trigger starts conversion when converter enabled
// - Trigger reset never sets timer overflow flag
// - PWM output with ten-bit duty resolution
// - Control zero forces PWM latch low
// - PWM cycle is period with high-time duty
// - Capture mode codes select edge and prescale
// - Compare mode codes select pin action
// - Zero off, one reserved, 11xx PWM
// - Capture sets flag, overwrites unread value
`include "ccp_regs.svh"

module ccp_unit
  import ccp_pkg::*;
#(
  parameter int DUTY_W = 10
) (
  input  wire logic              I_CLK,
  input  wire logic              I_RST,
  input  wire logic              I_CE,
  input  wire logic [1:0]        I_ADDR,
  input  wire logic [7:0]        I_WDATA,
  input  wire logic              I_WR,
  input  wire logic              I_RD,
  output logic      [7:0]        O_RDATA,
  input  wire logic              I_CAP_PIN,
  input  wire logic              I_CAN_RX_EVENT,
  input  wire logic              I_CAN_TS_SELECT,
  input  wire logic              I_TIMER_THREE_SEL,
  input  wire logic [15:0]       I_TIMER_ONE_COUNT,
  input  wire logic [15:0]       I_TIMER_THREE_COUNT,
  input  wire logic              I_AD_ENABLED,
  input  wire logic              I_PWM_PERIOD_END,
  input  wire logic [DUTY_W-1:0] I_PWM_TB_COUNT,
  output logic                   O_PIN,
  output logic                   O_FLAG,
  output logic                   O_IRQ,
  output logic                   O_TIMER_ONE_CLEAR,
  output logic                   O_TIMER_THREE_CLEAR,
  output logic                   O_AD_START
);

  // Software-visible registers and compare state
  // Flag itself is the O_FLAG register
  logic [7:0]  value_low;      // Value register low byte
  logic [7:0]  value_high;     // Value register high byte
  logic [5:0]  unit_control;   // Duty low bits and mode
  logic        flag_en;        // Interrupt enable bit
  logic        cmp_latch;      // Compare output latch
  logic        match_q;        // Previous match level

  // Next values
  // Registered outputs included
  logic [7:0]  next_value_low;
  logic [7:0]  next_value_high;
  logic [5:0]  next_unit_control;
  logic        next_flag;
  logic        next_flag_en;
  logic        next_cmp_latch;
  logic        next_match_q;
  logic [7:0]  next_rdata;
  logic        next_irq;
  logic        next_t1_clr;
  logic        next_t3_clr;
  logic        next_ad_start;

  // Decoded and derived signals
  // Combinational only, no state
  logic [3:0]  mode;           // Mode select field
  mode_kind_t  kind;           // Operating class
  logic [15:0] timer_sel;      // Selected time base
  logic [15:0] value_word;     // Full 16-bit value
  logic        match;          // Compare equality level
  logic        match_rise;     // First cycle of a match
  logic        cap_event;      // Capture event pulse
  logic        pwm_level;      // PWM latch level
  logic        wr_ctrl;        // Control write this cycle
  logic        pre_clear;      // Prescaler clear request
  logic        mode_switch;    // Direct capture-mode change
  logic        pwm_on;         // PWM active

  // Mode field of the control
  assign mode       = unit_control[`CCP_CTRL_MODE_MSB:0];
  // Value as one word
  assign value_word = {value_high, value_low};
  // Control write strobe
  assign wr_ctrl    = I_WR && (I_ADDR == `CCP_OFS_CONTROL);
  // PWM latch owns the pin
  assign pwm_on     = (kind == KIND_PWM);

  // mode class decode
  // Reserved code acts like off
  always_comb begin
    case (mode)
      `CCP_MODE_OFF:        kind = KIND_OFF;
      `CCP_MODE_RESERVED:   kind = KIND_RESERVED;
      // Capture codes
      `CCP_MODE_CAP_CAN,
      `CCP_MODE_CAP_FALL,
      `CCP_MODE_CAP_RISE,
      `CCP_MODE_CAP_RISE4,
      `CCP_MODE_CAP_RISE16: kind = KIND_CAPTURE;
      // Compare codes
      `CCP_MODE_CMP_TOGGLE,
      `CCP_MODE_CMP_HIGH,
      `CCP_MODE_CMP_LOW,
      `CCP_MODE_CMP_SOFT,
      `CCP_MODE_CMP_TRIG:   kind = KIND_COMPARE;
      // Every 11xx code is PWM
      default:              kind = KIND_PWM;
    endcase
  end

  always_comb begin
    // Counts share I_CLK, no synchroniser
    timer_sel  = I_TIMER_THREE_SEL ? I_TIMER_THREE_COUNT : I_TIMER_ONE_COUNT;
    match      = (kind == KIND_COMPARE) && (value_word == timer_sel);
    // one action per match, timer on this clock
    match_rise = match && !match_q;
  end

  // Capture-mode to capture-mode change without passing off
  // Leaving through off stays quiet
  always_comb begin
    mode_switch = wr_ctrl && (kind == KIND_CAPTURE)
                  && (I_WDATA[`CCP_CTRL_MODE_MSB:0] != mode)
                  && (I_WDATA[`CCP_CTRL_MODE_MSB:2] == 2'h1
                      || I_WDATA[`CCP_CTRL_MODE_MSB:0] == `CCP_MODE_CAP_CAN);
    pre_clear   = (kind != KIND_CAPTURE);
  end

  // Capture event source with prescaler
  // Counter held clear outside capture
  ccp_capture_events u_events (
    .i_clk     (I_CLK),
    .i_rst     (I_RST),
    .i_ce      (I_CE),
    .i_pin     (I_CAP_PIN),
    .i_can_rx  (I_CAN_RX_EVENT),
    .i_can_sel (I_CAN_TS_SELECT),
    .i_mode    (mode),
    .i_clear   (pre_clear),
    .o_event   (cap_event)
  );

  // PWM output latch
  // Duty word: low byte, two bits
  ccp_pwm_gen #(
    .DUTY_W (DUTY_W)
  ) u_pwm (
    .i_clk        (I_CLK),
    .i_rst        (I_RST),
    .i_ce         (I_CE),
    .i_active     (pwm_on),
    .i_period_end (I_PWM_PERIOD_END),
    .i_tb_count   (I_PWM_TB_COUNT),
    .i_duty_new   ({value_low, unit_control[`CCP_CTRL_DUTY_MSB:`CCP_CTRL_DUTY_LSB]}),
    .i_duty_high  (value_high),
    .o_level      (pwm_level)
  );

  // Register writes, capture and PWM reload of the value
  always_comb begin
    next_value_low    = value_low;
    next_value_high   = value_high;
    next_unit_control = unit_control;
    next_flag_en      = flag_en;
    // Software byte writes
    // Writes land on the next edge
    if (I_WR) begin
      case (I_ADDR)
        `CCP_OFS_VALUE_LOW:  next_value_low = I_WDATA;
        // High byte read-only while in PWM
        `CCP_OFS_VALUE_HIGH: next_value_high = pwm_on ? value_high : I_WDATA;
        `CCP_OFS_CONTROL:    next_unit_control = I_WDATA[5:0];
        `CCP_OFS_STATUS:     next_flag_en = I_WDATA[`CCP_STAT_ENABLE];
        default:             next_flag_en = flag_en;
      endcase
    end
    // Capture wins over a byte write
    // capture overwrites any unread value
    if (kind == KIND_CAPTURE && cap_event) begin
      next_value_low  = timer_sel[7:0];
      next_value_high = timer_sel[15:8];
    end
    // Reload wins over everything
    // duty high byte buffered at period end
    if (pwm_on && I_PWM_PERIOD_END) begin
      next_value_high = value_low;
    end
  end

  // Interrupt flag: hardware set wins over software clear
  always_comb begin
    next_flag = O_FLAG;
    // Software clears by writing one
    if (I_WR && I_ADDR == `CCP_OFS_STATUS && I_WDATA[`CCP_STAT_FLAG]) begin
      next_flag = 1'b0;
    end
    if (kind == KIND_CAPTURE && cap_event) begin
      next_flag = 1'b1;
    end
    // match sets flag with the pin action
    if (match_rise) begin
      next_flag = 1'b1;
    end
    // false flag on direct prescaler switch
    if (mode_switch) begin
      next_flag = 1'b1;
    end
    // flag reaches processor only when enabled
    next_irq = next_flag && next_flag_en;
  end

  // Compare output latch and match history
  always_comb begin
    next_cmp_latch = cmp_latch;
    next_match_q   = match;
    // Later steps take priority
    // pin action on match
    if (match_rise) begin
      case (mode)
        `CCP_MODE_CMP_TOGGLE: next_cmp_latch = ~cmp_latch;
        `CCP_MODE_CMP_HIGH:   next_cmp_latch = 1'b1;
        `CCP_MODE_CMP_LOW:    next_cmp_latch = 1'b0;
        `CCP_MODE_CMP_SOFT:   next_cmp_latch = cmp_latch;
        default:              next_cmp_latch = cmp_latch;
      endcase
    end
    // A control write of a drive mode or of zero overrides a match
    // Initial level when a drive mode is written
    if (wr_ctrl) begin
      case (I_WDATA[`CCP_CTRL_MODE_MSB:0])
        `CCP_MODE_CMP_HIGH: next_cmp_latch = 1'b0;
        `CCP_MODE_CMP_LOW:  next_cmp_latch = 1'b1;
        default:            next_cmp_latch = next_cmp_latch;
      endcase
      if (I_WDATA == `CCP_CTRL_RESET) begin
        next_cmp_latch = 1'b0;
      end
    end
  end

  // Special event trigger pulses
  always_comb begin
    // Idle low between matches
    next_t1_clr   = 1'b0;
    next_t3_clr   = 1'b0;
    next_ad_start = 1'b0;
    if (match_rise && mode == `CCP_MODE_CMP_TRIG) begin
      next_t1_clr   = !I_TIMER_THREE_SEL;
      next_t3_clr   = I_TIMER_THREE_SEL;
      next_ad_start = I_AD_ENABLED;
    end
  end

  // Read data for the cycle after the strobe
  always_comb begin
    // Zero outside a read cycle
    next_rdata = 8'h00;
    if (I_RD) begin
      case (I_ADDR)
        `CCP_OFS_VALUE_LOW:  next_rdata = value_low;
        `CCP_OFS_VALUE_HIGH: next_rdata = value_high;
        // Reserved control bits read zero
        `CCP_OFS_CONTROL:    next_rdata = {2'h0, unit_control};
        `CCP_OFS_STATUS:     next_rdata = {6'h00, flag_en, O_FLAG};
        default:             next_rdata = 8'h00;
      endcase
    end
  end

  // Register update; all state frozen while I_CE low
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      // Unit off, pin and pulses low
      value_low           <= 8'h00;
      value_high          <= 8'h00;
      unit_control        <= 6'h00;
      flag_en             <= 1'b0;
      cmp_latch           <= 1'b0;
      match_q             <= 1'b0;
      O_RDATA             <= 8'h00;
      O_PIN               <= 1'b0;
      O_FLAG              <= 1'b0;
      O_IRQ               <= 1'b0;
      O_TIMER_ONE_CLEAR   <= 1'b0;
      O_TIMER_THREE_CLEAR <= 1'b0;
      O_AD_START          <= 1'b0;
    end else if (I_CE) begin
      // Each register takes its next value
      value_low           <= next_value_low;
      value_high          <= next_value_high;
      unit_control        <= next_unit_control;
      flag_en             <= next_flag_en;
      cmp_latch           <= next_cmp_latch;
      match_q             <= next_match_q;
      O_RDATA             <= next_rdata;
      O_PIN               <= pwm_on ? pwm_level : next_cmp_latch;
      O_FLAG              <= next_flag;
      O_IRQ               <= next_irq;
      O_TIMER_ONE_CLEAR   <= next_t1_clr;
      O_TIMER_THREE_CLEAR <= next_t3_clr;
      O_AD_START          <= next_ad_start;
    end
  end

endmodule : ccp_unit

// >>> sim/ccp_far_side.sv
/*
  Far-side model: timers one and three, PWM time base, capture pin and
  message-received pulse. Assumes one clock shared with the unit.
*/
module ccp_far_side #(
  parameter int PER = 63
) (
  input  wire logic   i_clk,
  input  wire logic   i_rst,
  input  wire logic   i_run,
  input  wire logic   i_clr1,
  input  wire logic   i_clr3,
  output logic        o_pin,
  output logic        o_can_rx,
  output logic        o_period_end,
  output logic [15:0] o_t1,
  output logic [15:0] o_t3,
  output logic [9:0]  o_tb
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_t1 <= 16'h0000;
      o_t3 <= 16'h8000;
      o_tb <= 10'h000;
    end else begin
      o_t1 <= i_clr1 ? 16'h0000 : o_t1 + 16'(i_run);
      o_t3 <= i_clr3 ? 16'h0000 : o_t3 + 16'(i_run);
      o_tb <= (o_tb == 10'(PER)) ? 10'h000 : o_tb + 10'h001;
    end
  end
  assign o_period_end = (o_tb == 10'(PER));
  initial begin
    o_pin = 1'b0;
    o_can_rx = 1'b0;
  end
  // One rise and one fall on the pin
  task pulse_pin;
    @(posedge i_clk) o_pin <= 1'b1;
    repeat (8) @(posedge i_clk);
    o_pin <= 1'b0;
    repeat (8) @(posedge i_clk);
  endtask : pulse_pin
  task can_msg;
    @(posedge i_clk) o_can_rx <= 1'b1;
    repeat (2) @(posedge i_clk);
    o_can_rx <= 1'b0;
    repeat (8) @(posedge i_clk);
  endtask : can_msg
endmodule : ccp_far_side

// >>> sim/ccp_unit_properties.sv
/*
  Port checker for ccp_unit: read data, compare actions, trigger pulses,
  capture latency. Assumes I_CE is held high by the bench.
*/
`include "ccp_regs.svh"

module ccp_unit_properties #(
  parameter int DUTY_W = 10
) (
  input wire logic       I_CLK,
  input wire logic       I_RST,
  input wire logic       I_CE,
  input wire logic [1:0] I_ADDR,
  input wire logic [7:0] I_WDATA,
  input wire logic       I_WR,
  input wire logic       I_RD,
  input wire logic [7:0] O_RDATA,
  input wire logic       I_CAP_PIN,
  input wire logic       I_CAN_TS_SELECT,
  input wire logic       I_TIMER_THREE_SEL,
  input wire logic       I_AD_ENABLED,
  input wire logic       O_PIN,
  input wire logic       O_FLAG,
  input wire logic       O_IRQ,
  input wire logic       O_TIMER_ONE_CLEAR,
  input wire logic       O_TIMER_THREE_CLEAR,
  input wire logic       O_AD_START
);
  logic [3:0] mode;      // Shadow of the mode field
  logic [3:0] next_mode; // Mode after this cycle
  logic       clr;       // Either timer clear pulse
  assign clr = O_TIMER_ONE_CLEAR || O_TIMER_THREE_CLEAR;
  // Follows control writes
  always_comb begin
    next_mode = mode;
    if (I_CE && I_WR && I_ADDR == `CCP_OFS_CONTROL) next_mode = I_WDATA[3:0];
  end
  // Registers the shadow
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) mode <= 4'h0;
    else mode <= next_mode;
  end
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RST);
  sequence s_ctrl_wr(logic [3:0] m);
    I_CE && I_WR && I_ADDR == `CCP_OFS_CONTROL && I_WDATA[3:0] == m;
  endsequence
  sequence s_held(logic [3:0] m);
    mode == m && $past(mode) == m && $past(mode, 2) == m;
  endsequence
  chk_rdata_idle: assert property (I_CE && !I_RD |=> O_RDATA == 8'h00)
    else $error("read data not zero outside a read");
  chk_trig_flag: assert property (clr |-> O_FLAG)
    else $error("trigger without flag");
  chk_trig_base: assert property (clr |-> O_TIMER_THREE_CLEAR == $past(I_TIMER_THREE_SEL)
    && O_TIMER_ONE_CLEAR != O_TIMER_THREE_CLEAR)
    else $error("trigger cleared the wrong timer");
  chk_trig_once: assert property (clr |=> !clr)
    else $error("trigger pulse longer than one cycle");
  chk_ad_start: assert property (O_AD_START == (clr && $past(I_AD_ENABLED)))
    else $error("conversion start mismatch");
  chk_off_pin: assert property (s_held(4'h0) |-> !O_PIN && !clr)
    else $error("pin or trigger active while off");
  chk_soft_pin: assert property (s_held(4'hA) |-> $stable(O_PIN))
    else $error("pin moved in software mode");
  chk_init_high: assert property (s_ctrl_wr(4'h9) |-> ##[1:2] O_PIN)
    else $error("pin not initialised high");
  chk_init_low: assert property (s_ctrl_wr(4'h8) |-> ##[1:2] !O_PIN)
    else $error("pin not initialised low");
  chk_cap_rise: assert property (mode == 4'h5 && !I_CAN_TS_SELECT && $rose(I_CAP_PIN) |-> ##[2:6] O_FLAG)
    else $error("rising edge not captured");
  chk_cap_fall: assert property (mode == 4'h4 && !I_CAN_TS_SELECT && $fell(I_CAP_PIN) |-> ##[2:6] O_FLAG)
    else $error("falling edge not captured");
  chk_irq_flag: assert property (O_IRQ |-> O_FLAG || $past(O_FLAG))
    else $error("interrupt without flag");
endmodule : ccp_unit_properties

bind ccp_unit ccp_unit_properties #(.DUTY_W(DUTY_W)) u_props (
  .I_CLK(I_CLK), .I_RST(I_RST), .I_CE(I_CE), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA),
  .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA), .I_CAP_PIN(I_CAP_PIN),
  .I_CAN_TS_SELECT(I_CAN_TS_SELECT), .I_TIMER_THREE_SEL(I_TIMER_THREE_SEL),
  .I_AD_ENABLED(I_AD_ENABLED), .O_PIN(O_PIN), .O_FLAG(O_FLAG), .O_IRQ(O_IRQ),
  .O_TIMER_ONE_CLEAR(O_TIMER_ONE_CLEAR), .O_TIMER_THREE_CLEAR(O_TIMER_THREE_CLEAR),
  .O_AD_START(O_AD_START));

// >>> sim/ccp_unit_tb.sv
/*
  Bench for ccp_unit: registers, capture, timestamp, compare, trigger, PWM.
  Assumes ccp_far_side as far side and the bound checker.
*/
`include "ccp_regs.svh"

module ccp_unit_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst, wr, rd, ts_sel, t3_sel, ad_en, run;
  logic        pin, can_rx, pend, o_pin, flag, irq, clr1, clr3, ad_st;
  logic [1:0]  addr;
  logic [7:0]  wdata, rdata, d, lo;
  logic [15:0] t1, t3, v;
  logic [9:0]  tb;
  int          fails, n_compared;
  logic [3:0]  cap_m [4] = '{4'h5, 4'h4, 4'h6, 4'h7};
  int          cap_n [4] = '{1, 1, 4, 16};
  logic [3:0]  cmp_m [6] = '{4'h8, 4'h9, 4'hB, 4'hB, 4'hA, 4'h2};
  logic        cmp_p [6] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};

  ccp_unit #(.DUTY_W(10)) u_dut (.I_CLK(clk), .I_RST(rst), .I_CE(1'b1), .I_ADDR(addr),
    .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_CAP_PIN(pin),
    .I_CAN_RX_EVENT(can_rx), .I_CAN_TS_SELECT(ts_sel), .I_TIMER_THREE_SEL(t3_sel),
    .I_TIMER_ONE_COUNT(t1), .I_TIMER_THREE_COUNT(t3), .I_AD_ENABLED(ad_en),
    .I_PWM_PERIOD_END(pend), .I_PWM_TB_COUNT(tb), .O_PIN(o_pin), .O_FLAG(flag), .O_IRQ(irq),
    .O_TIMER_ONE_CLEAR(clr1), .O_TIMER_THREE_CLEAR(clr3), .O_AD_START(ad_st));
  ccp_far_side u_far (.i_clk(clk), .i_rst(rst), .i_run(run), .i_clr1(clr1), .i_clr3(clr3),
    .o_pin(pin), .o_can_rx(can_rx), .o_period_end(pend), .o_t1(t1), .o_t3(t3), .o_tb(tb));

  // 250 MHz clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task chkv(input string n, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask : chkv
  task chkb(input string n, input logic e, input logic g);
    chkv(n, {15'h0000, e}, {15'h0000, g});
  endtask : chkb
  task wr_reg(input logic [1:0] a, input logic [7:0] x);
    @(posedge clk) begin wr <= 1'b1; addr <= a; wdata <= x; end
    @(posedge clk) wr <= 1'b0;
  endtask : wr_reg
  task rd_reg(input logic [1:0] a, output logic [7:0] x);
    @(posedge clk) begin rd <= 1'b1; addr <= a; end
    @(posedge clk) rd <= 1'b0;
    #1 x = rdata;
  endtask : rd_reg
  task summarize;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : summarize
  // Bounded wait for the sticky flag
  task wait_flag;
    for (int i = 0; i < 400; i++) begin
      @(posedge clk);
      #1;
      if (flag === 1'b1) return;
    end
    fails++;
    $display("BAD flag wait exp 1 got %b", flag);
    summarize();
  endtask : wait_flag
  task t_regs;
    rd_reg(`CCP_OFS_CONTROL, d);
    chkv("control reset", {8'h00, `CCP_CTRL_RESET}, {8'h00, d});
    rd_reg(`CCP_OFS_STATUS, d);
    chkv("status reset", 16'h0000, {8'h00, d});
    wr_reg(`CCP_OFS_CONTROL, 8'hFA);
    rd_reg(`CCP_OFS_CONTROL, d);
    chkv("control bits", 16'h003A, {8'h00, d});
    $display("test regs done");
  endtask : t_regs
  task t_capture;
    for (int k = 0; k < 4; k++) begin
      t3_sel <= cap_m[k][1];
      wr_reg(`CCP_OFS_CONTROL, 8'h00);
      wr_reg(`CCP_OFS_CONTROL, {4'h0, cap_m[k]});
      wr_reg(`CCP_OFS_STATUS, 8'h01);
      run <= 1'b0;
      for (int j = 1; j < cap_n[k]; j++) u_far.pulse_pin();
      #1 chkb("early flag", 1'b0, flag);
      u_far.pulse_pin();
      wait_flag();
      v = t3_sel ? t3 : t1;
      rd_reg(`CCP_OFS_VALUE_LOW, lo);
      rd_reg(`CCP_OFS_VALUE_HIGH, d);
      chkv("capture value", v, {d, lo});
      run <= 1'b1;
    end
    wr_reg(`CCP_OFS_STATUS, 8'h01);
    wr_reg(`CCP_OFS_CONTROL, 8'h06);
    rd_reg(`CCP_OFS_STATUS, d);
    chkb("switch flag", 1'b1, d[`CCP_STAT_FLAG]);
    $display("test capture done");
  endtask : t_capture
  task t_can;
    t3_sel <= 1'b0;
    ts_sel <= 1'b1;
    run <= 1'b0;
    wr_reg(`CCP_OFS_CONTROL, 8'h00);
    wr_reg(`CCP_OFS_CONTROL, 8'h05);
    wr_reg(`CCP_OFS_STATUS, 8'h03);
    u_far.pulse_pin();
    #1 chkb("pin ignored", 1'b0, flag);
    u_far.can_msg();
    wait_flag();
    chkb("irq enabled", 1'b1, irq);
    rd_reg(`CCP_OFS_VALUE_LOW, lo);
    rd_reg(`CCP_OFS_VALUE_HIGH, d);
    chkv("stamp value", t1, {d, lo});
    run <= 1'b1;
    repeat (5) @(posedge clk);
    run <= 1'b0;
    u_far.can_msg();
    rd_reg(`CCP_OFS_VALUE_LOW, lo);
    rd_reg(`CCP_OFS_VALUE_HIGH, d);
    chkv("overwrite value", t1, {d, lo});
    wr_reg(`CCP_OFS_STATUS, 8'h01);
    rd_reg(`CCP_OFS_STATUS, d);
    chkv("status clear", 16'h0000, {8'h00, d});
    wr_reg(`CCP_OFS_CONTROL, 8'h00);
    wr_reg(`CCP_OFS_CONTROL, 8'h03);
    u_far.can_msg();
    wait_flag();
    chkb("message mode", 1'b1, flag);
    ts_sel <= 1'b0;
    run <= 1'b1;
    $display("test stamp done");
  endtask : t_can
  task t_compare;
    for (int k = 0; k < 6; k++) begin
      t3_sel <= (k == 2);
      ad_en <= (k == 2);
      wr_reg(`CCP_OFS_CONTROL, 8'h00);
      v = ((k == 2) ? t3 : t1) + 16'h0040;
      wr_reg(`CCP_OFS_VALUE_LOW, v[7:0]);
      wr_reg(`CCP_OFS_VALUE_HIGH, v[15:8]);
      wr_reg(`CCP_OFS_STATUS, 8'h01);
      wr_reg(`CCP_OFS_CONTROL, {4'h0, cmp_m[k]});
      wait_flag();
      chkb("compare pin", cmp_p[k], o_pin);
      chkb("clear one", k == 3, clr1);
      chkb("clear three", k == 2, clr3);
      chkb("ad start", k == 2, ad_st);
    end
    wr_reg(`CCP_OFS_CONTROL, 8'h00);
    repeat (2) @(posedge clk);
    #1 chkb("pin off", 1'b0, o_pin);
    $display("test compare done");
  endtask : t_compare
  task t_pwm;
    wr_reg(`CCP_OFS_VALUE_LOW, 8'h04);
    wr_reg(`CCP_OFS_CONTROL, 8'h2C);
    repeat (200) @(posedge clk);
    wr_reg(`CCP_OFS_VALUE_HIGH, 8'h55);
    rd_reg(`CCP_OFS_VALUE_HIGH, d);
    chkv("duty latch", 16'h0004, {8'h00, d});
    v = 16'h0000;
    repeat (128) begin
      @(posedge clk);
      #1 v = v + {15'h0000, o_pin};
    end
    chkv("pwm high time", 16'h0024, v);
    wr_reg(`CCP_OFS_CONTROL, 8'h00);
    repeat (2) @(posedge clk);
    #1 chkb("pwm off pin", 1'b0, o_pin);
    $display("test pwm done");
  endtask : t_pwm
  // Reset, then the scenarios
  initial begin
    rst = 1'b1;
    {wr, rd, ts_sel, t3_sel, ad_en} = 5'h00;
    run = 1'b1;
    addr = 2'h0;
    wdata = 8'h00;
    fails = 0;
    n_compared = 0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_capture();
    t_can();
    t_compare();
    t_pwm();
    summarize();
  end
endmodule : ccp_unit_tb
